// [design/cwc_top.sv]
// How it works
// - Frequency mode duty is measured frequency over full-scale field.
// - Enter idle after speed below threshold for 50us/200us/20ms/200ms.
// - Auto current-amp gain enable gives a 1 ms adjust strobe; else fixed.
// - Auto voltage gain enable gives a 1 ms adjust strobe; else none.
// - Low-power select picks standby (0) or sleep (1) as idle state.
// - Clock source code 0 internal, 3 external; 1 and 2 undefined.
// - External clock used only when its enable bit is set.
// - External rate code gives 8 kHz doubling up to 1024 kHz.
// - Watchdog monitored only while its enable bit is set.
// - Tickle interval 100/200/500/1000 ms GPIO, tenfold in I2C mode.
// - Tickle source bit: 0 takes I2C tickles, 1 takes GPIO pin tickles.
// - Missed tickle reports fault; with action bit set also latches Hi-Z.
// - Peripheral word resets to 40000000h.
// - Peripheral bit 30 set disables clock dithering.
// - Device word sits at A8h and resets to zero.
`timescale 1ns/1ps
`include "cwc_regs.svh"
module cwc_top #(
  parameter int SLEEP_C0 = `CWC_SLEEP_C0,
  parameter int SLEEP_C1 = `CWC_SLEEP_C1,
  parameter int SLEEP_C2 = `CWC_SLEEP_C2,
  parameter int SLEEP_C3 = `CWC_SLEEP_C3,
  parameter int MS_CYCLES = `CWC_MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_ff,
  input wire logic freq_mode,
  input wire logic meas_valid,
  input wire logic [14:0] meas_freq,
  output cwc_pkg::cwc_duty_type duty_ff,
  input wire logic speed_below,
  output logic standby_ff,
  output logic sleep_ff,
  output logic cur_gain_adj_ff,
  output logic volt_gain_adj_ff,
  output logic clk_source_ext_ff,
  output logic clk_sel_invalid_ff,
  output logic [10:0] ext_clk_rate_khz_ff,
  output logic dither_clock_off_ff,
  input wire logic tickle_pin,
  input wire logic i2c_tickle,
  input wire logic fault_clear,
  output logic wd_fault_ff,
  output logic outputs_hiz_ff
);
  import cwc_pkg::*;

  cwc_dev_cfg_type dev_cfg_ff;
  logic [31:0] peri_ff;
  logic [24:0] ms_cnt_ff;
  logic ms_tick_ff;
  logic [24:0] sleep_cnt_ff;
  logic [24:0] sleep_lim;
  logic [1:0] pin_sync_ff;
  logic pin_prev_ff;
  logic tickle_ok;
  logic [13:0] wd_cnt_ff;
  logic [13:0] wd_lim;
  logic wd_expire;
  logic div_busy_ff;
  logic [3:0] div_step_ff;
  logic [15:0] div_rem_ff;
  logic [14:0] div_q_ff;
  logic [15:0] nxt_rem;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_cfg_ff <= `CWC_RST_DEV_CFG;
      peri_ff <= `CWC_RST_PERI;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `CWC_ADDR_DEV_CFG)
        dev_cfg_ff <= reg_wdata;
      if (reg_addr == `CWC_ADDR_PERI)
        peri_ff <= reg_wdata;
    end
  end

  // Unmapped reads return zero so the host can probe safely
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata_ff <= (reg_addr == `CWC_ADDR_DEV_CFG) ? dev_cfg_ff :
                      (reg_addr == `CWC_ADDR_PERI) ? peri_ff : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dither_clock_off_ff <= 1'b1;
      clk_source_ext_ff <= 1'b0;
      clk_sel_invalid_ff <= 1'b0;
      ext_clk_rate_khz_ff <= `CWC_EXT_BASE_KHZ;
    end
    else
    begin
      dither_clock_off_ff <= peri_ff[`CWC_DITHER_OFF_BIT];
      clk_source_ext_ff <= (dev_cfg_ff.clock_source == 2'h3) && dev_cfg_ff.outside_clock_on;
      clk_sel_invalid_ff <= (dev_cfg_ff.clock_source == 2'h1) || (dev_cfg_ff.clock_source == 2'h2);
      ext_clk_rate_khz_ff <= `CWC_EXT_BASE_KHZ << dev_cfg_ff.outside_clock_rate;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Free-running millisecond base shared by gain strobes and watchdog
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt_ff <= 25'h000_0000;
      ms_tick_ff <= 1'b0;
    end
    else
    begin
      ms_tick_ff <= (ms_cnt_ff == 25'(MS_CYCLES - 1));
      ms_cnt_ff <= (ms_cnt_ff == 25'(MS_CYCLES - 1)) ? 25'h000_0000 : ms_cnt_ff + 25'h000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_gain_adj_ff <= 1'b0;
      volt_gain_adj_ff <= 1'b0;
    end
    else
    begin
      cur_gain_adj_ff <= ms_tick_ff && dev_cfg_ff.auto_current_amp_gain_on;
      volt_gain_adj_ff <= ms_tick_ff && dev_cfg_ff.auto_voltage_gain_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    unique case (dev_cfg_ff.sleep_delay)
      2'h0: sleep_lim = 25'(SLEEP_C0 - 1);
      2'h1: sleep_lim = 25'(SLEEP_C1 - 1);
      2'h2: sleep_lim = 25'(SLEEP_C2 - 1);
      2'h3: sleep_lim = 25'(SLEEP_C3 - 1);
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_cnt_ff <= 25'h000_0000;
      standby_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end
    else if (!speed_below)
    begin
      sleep_cnt_ff <= 25'h000_0000;
      standby_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end
    else if (sleep_cnt_ff >= sleep_lim)
    begin
      if (!standby_ff && !sleep_ff)
      begin
        sleep_ff <= dev_cfg_ff.low_power_select;
        standby_ff <= !dev_cfg_ff.low_power_select;
      end
    end
    else
      sleep_cnt_ff <= sleep_cnt_ff + 25'h000_0001;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync_ff <= 2'b00;
      pin_prev_ff <= 1'b0;
    end
    else
    begin
      pin_sync_ff <= {pin_sync_ff[0], tickle_pin};
      pin_prev_ff <= pin_sync_ff[1];
    end
  end

  assign tickle_ok = dev_cfg_ff.tickle_source ? (pin_sync_ff[1] && !pin_prev_ff) : i2c_tickle;

  always_comb
  begin
    unique case (dev_cfg_ff.tickle_interval)
      2'h0: wd_lim = 14'(`CWC_WD_T0_MS);
      2'h1: wd_lim = 14'(`CWC_WD_T1_MS);
      2'h2: wd_lim = 14'(`CWC_WD_T2_MS);
      2'h3: wd_lim = 14'(`CWC_WD_T3_MS);
    endcase
    if (!dev_cfg_ff.tickle_source)
      wd_lim = 14'(wd_lim * `CWC_WD_I2C_SCALE);
  end

  assign wd_expire = dev_cfg_ff.host_watchdog_on && ms_tick_ff && (wd_cnt_ff >= wd_lim - 14'h0001);

  // Counter counts elapsed milliseconds since the last tickle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_cnt_ff <= 14'h0000;
    else if (!dev_cfg_ff.host_watchdog_on || tickle_ok || wd_expire)
      wd_cnt_ff <= 14'h0000;
    else if (ms_tick_ff)
      wd_cnt_ff <= wd_cnt_ff + 14'h0001;
  end

  // Set beats clear so an expiry in the clearing cycle is never lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_fault_ff <= 1'b0;
      outputs_hiz_ff <= 1'b0;
    end
    else
    begin
      if (wd_expire)
        wd_fault_ff <= 1'b1;
      else if (fault_clear)
        wd_fault_ff <= 1'b0;
      if (wd_expire && dev_cfg_ff.watchdog_fault_action)
        outputs_hiz_ff <= 1'b1;
      else if (fault_clear)
        outputs_hiz_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Restoring divider, one quotient bit per clock; new samples are dropped while busy
  assign nxt_rem = {div_rem_ff[14:0], 1'b0};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_busy_ff <= 1'b0;
      div_step_ff <= 4'h0;
      div_rem_ff <= 16'h0000;
      div_q_ff <= 15'h0000;
      duty_ff <= '0;
    end
    else
    begin
      duty_ff.valid <= 1'b0;
      if (!div_busy_ff)
      begin
        if (freq_mode && meas_valid)
        begin
          if (meas_freq >= dev_cfg_ff.full_scale_input_freq)
          begin
            duty_ff.duty <= `CWC_DUTY_FULL;
            duty_ff.valid <= 1'b1;
          end
          else
          begin
            div_busy_ff <= 1'b1;
            div_step_ff <= 4'h0;
            div_rem_ff <= {1'b0, meas_freq};
            div_q_ff <= 15'h0000;
          end
        end
      end
      else
      begin
        if (nxt_rem >= {1'b0, dev_cfg_ff.full_scale_input_freq})
        begin
          div_rem_ff <= nxt_rem - {1'b0, dev_cfg_ff.full_scale_input_freq};
          div_q_ff <= {div_q_ff[13:0], 1'b1};
        end
        else
        begin
          div_rem_ff <= nxt_rem;
          div_q_ff <= {div_q_ff[13:0], 1'b0};
        end
        div_step_ff <= div_step_ff + 4'h1;
        if (div_step_ff == 4'(`CWC_DIV_STEPS - 1))
        begin
          div_busy_ff <= 1'b0;
          duty_ff.duty <= {1'b0, div_q_ff[13:0], (nxt_rem >= {1'b0, dev_cfg_ff.full_scale_input_freq})};
          duty_ff.valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence div_launch;
    !div_busy_ff && freq_mode && meas_valid;
  endsequence

  sequence div_result;
    ##[1:16] duty_ff.valid;
  endsequence

  chk_div_result: assert property (@(posedge clk) disable iff (!rst_n) div_launch |-> div_result)
    else $error("Duty result not produced in time");
  chk_sleep_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sleep_ff || standby_ff) |-> $past(sleep_cnt_ff) >= $past(sleep_lim))
    else $error("Idle entered before delay elapsed");
  chk_cur_gain_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    cur_gain_adj_ff |-> $past(ms_tick_ff) && $past(dev_cfg_ff.auto_current_amp_gain_on))
    else $error("Current gain adjusted while disabled");
  chk_volt_gain_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    volt_gain_adj_ff |-> $past(ms_tick_ff) && $past(dev_cfg_ff.auto_voltage_gain_on))
    else $error("Voltage gain adjusted while disabled");
  chk_idle_select: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sleep_ff || standby_ff) |-> sleep_ff == $past(dev_cfg_ff.low_power_select))
    else $error("Wrong idle state chosen");
  chk_ext_clk_sel: assert property (@(posedge clk) disable iff (!rst_n)
    clk_source_ext_ff |-> $past(dev_cfg_ff.outside_clock_on) && $past(dev_cfg_ff.clock_source) == 2'h3)
    else $error("External clock selected without enable");
  chk_ext_rate: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ext_clk_rate_khz_ff == (`CWC_EXT_BASE_KHZ << $past(dev_cfg_ff.outside_clock_rate)))
    else $error("External rate mismatch");
  chk_wd_held_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !dev_cfg_ff.host_watchdog_on |=> wd_cnt_ff == 14'h0000 && !$rose(wd_fault_ff))
    else $error("Watchdog counting while disabled");
  chk_hiz_latch: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(outputs_hiz_ff) |-> wd_fault_ff && $past(dev_cfg_ff.watchdog_fault_action))
    else $error("Hi-Z latched without fault action");
  chk_sleep_restart: assert property (@(posedge clk) disable iff (!rst_n)
    !speed_below |=> sleep_cnt_ff == 25'h000_0000 && !sleep_ff && !standby_ff)
    else $error("Sleep timer not restarted");
  chk_peri_dither: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `CWC_ADDR_PERI |=> ##1 dither_clock_off_ff == $past(reg_wdata[30], 2))
    else $error("Dither disable not following register");
endmodule

// [design/cwc_regs.svh]
`ifndef CWC_REGS_SVH
`define CWC_REGS_SVH
`define CWC_ADDR_DEV_CFG 8'hA8
`define CWC_ADDR_PERI 8'hAA
`define CWC_RST_DEV_CFG 32'h0000_0000
`define CWC_RST_PERI 32'h4000_0000
`define CWC_DITHER_OFF_BIT 30
`define CWC_CLK_KHZ 125000
`define CWC_CLK_MHZ 125
`define CWC_SLEEP_T0_US 50
`define CWC_SLEEP_T1_US 200
`define CWC_SLEEP_T2_US 20000
`define CWC_SLEEP_T3_US 200000
`define CWC_SLEEP_C0 (`CWC_SLEEP_T0_US * `CWC_CLK_MHZ)
`define CWC_SLEEP_C1 (`CWC_SLEEP_T1_US * `CWC_CLK_MHZ)
`define CWC_SLEEP_C2 (`CWC_SLEEP_T2_US * `CWC_CLK_MHZ)
`define CWC_SLEEP_C3 (`CWC_SLEEP_T3_US * `CWC_CLK_MHZ)
`define CWC_GAIN_T_MS 1
`define CWC_MS_CYCLES (`CWC_GAIN_T_MS * `CWC_CLK_KHZ)
`define CWC_WD_T0_MS 100
`define CWC_WD_T1_MS 200
`define CWC_WD_T2_MS 500
`define CWC_WD_T3_MS 1000
`define CWC_WD_I2C_SCALE 10
`define CWC_EXT_BASE_KHZ 11'h008
`define CWC_DIV_STEPS 15
`define CWC_DUTY_FULL 16'h8000
`endif

// [design/cwc_pkg.sv]
package cwc_pkg;
  typedef struct packed {
    logic parity;
    logic [14:0] full_scale_input_freq;
    logic [1:0] sleep_delay;
    logic auto_current_amp_gain_on;
    logic auto_voltage_gain_on;
    logic low_power_select;
    logic [1:0] clock_source;
    logic outside_clock_on;
    logic [2:0] outside_clock_rate;
    logic host_watchdog_on;
    logic [1:0] tickle_interval;
    logic tickle_source;
    logic watchdog_fault_action;
  } cwc_dev_cfg_type;

  typedef struct packed {
    logic [15:0] duty;
    logic valid;
  } cwc_duty_type;
endpackage

// [tb/cwc_host.sv]
`timescale 1ns/1ps
module cwc_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_ff,
  output logic tickle_pin,
  output logic i2c_tickle
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    tickle_pin = 1'b0;
    i2c_tickle = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released data lines must not look like the last word
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata_ff;
  endtask
  // Tickle on the pin or as a one-cycle pulse on the serial side
  task automatic tickle(input logic gpio);
    @(negedge clk);
    tickle_pin = gpio;
    i2c_tickle = ~gpio;
    @(negedge clk);
    i2c_tickle = 1'b0;
    @(negedge clk);
    tickle_pin = 1'b0;
  endtask
endmodule

// [tb/cwc_top_test.sv]
`timescale 1ns/1ps
module cwc_top_test;
  import cwc_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, freq_mode, meas_valid, speed_below;
  logic tickle_pin, i2c_tickle, fault_clear, standby_ff, sleep_ff, cur_gain_adj_ff;
  logic volt_gain_adj_ff, clk_source_ext_ff, clk_sel_invalid_ff, dither_clock_off_ff;
  logic wd_fault_ff, outputs_hiz_ff;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, d;
  logic [14:0] meas_freq;
  logic [10:0] ext_clk_rate_khz_ff;
  cwc_duty_type duty_ff;
  logic [31:0] shadow[int];
  int bad_count, tests_run, cycles, k, n, fi, mi, cc, cv, pd, rl;
  int seed = 32'h07e8_a0b1;
  cwc_top #(.SLEEP_C0(8), .SLEEP_C1(16), .SLEEP_C2(32), .SLEEP_C3(64), .MS_CYCLES(20)) cwc_top_i (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .freq_mode(freq_mode),
    .meas_valid(meas_valid), .meas_freq(meas_freq), .duty_ff(duty_ff), .speed_below(speed_below),
    .standby_ff(standby_ff), .sleep_ff(sleep_ff), .cur_gain_adj_ff(cur_gain_adj_ff),
    .volt_gain_adj_ff(volt_gain_adj_ff), .clk_source_ext_ff(clk_source_ext_ff),
    .clk_sel_invalid_ff(clk_sel_invalid_ff), .ext_clk_rate_khz_ff(ext_clk_rate_khz_ff),
    .dither_clock_off_ff(dither_clock_off_ff), .tickle_pin(tickle_pin), .i2c_tickle(i2c_tickle),
    .fault_clear(fault_clear), .wd_fault_ff(wd_fault_ff), .outputs_hiz_ff(outputs_hiz_ff));
  cwc_host cwc_host_i (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .tickle_pin(tickle_pin), .i2c_tickle(i2c_tickle));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    cwc_host_i.wr(a, v);
    if (shadow.exists(a))
      shadow[a] = v;
  endtask
  task automatic rchk(input logic [7:0] a);
    cwc_host_i.rd(a, d);
    cmp(d, shadow.exists(a) ? shadow[a] : 32'h0000_0000, "read");
  endtask
  task automatic wait_fault(input int lim);
    k = 0;
    while (wd_fault_ff !== 1'b1 && k < lim)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    freq_mode = 1'b0;
    meas_valid = 1'b0;
    meas_freq = 15'h0000;
    speed_below = 1'b0;
    fault_clear = 1'b0;
    shadow[8'hA8] = 32'h0000_0000;
    shadow[8'hAA] = 32'h4000_0000;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    cmp(dither_clock_off_ff, 1, "dither rst");
    cmp(ext_clk_rate_khz_ff, 8, "rate rst");
    rchk(8'hA8);
    rchk(8'hAA);
    w(8'hA9, $random(seed));
    rchk(8'hA9);
    for (int i = 0; i < 2; i++)
    begin
      d = $random(seed);
      d[30] = i[0];
      w(8'hAA, d);
      w(8'hA8, ~d);
      rchk(8'hAA);
      rchk(8'hA8);
      cmp(dither_clock_off_ff, i[0], "dither");
    end
    for (int c = 0; c < 4; c++)
      for (int e = 0; e < 2; e++)
      begin
        n = c * 2 + e;
        w(8'hA8, 32'(c) << 9 | 32'(e) << 8 | 32'(n) << 5);
        repeat (2) @(negedge clk);
        cmp({clk_source_ext_ff, clk_sel_invalid_ff}, {c == 3 && e == 1, c == 1 || c == 2}, "src");
        cmp(ext_clk_rate_khz_ff, 8 << n, "rate");
      end
    for (int i = 0; i < 6; i++)
    begin
      fi = (i == 0) ? 2 : (i == 4) ? 0 : (i == 5) ? 32'h7fff : $random(seed) & 32'h7fff;
      mi = (i == 0) ? 1 : $random(seed) & 32'h7fff;
      // With the mode off a sample must leave the last duty untouched
      freq_mode = (i == 5) ? 1'b0 : (i == 0 || i == 4) ? 1'b1 : 1'($random(seed));
      w(8'hA8, 32'(fi) << 16);
      @(negedge clk);
      meas_valid = 1'b1;
      meas_freq = mi[14:0];
      @(negedge clk);
      meas_valid = 1'b0;
      meas_freq = ~mi[14:0];
      k = 0;
      while (duty_ff.valid !== 1'b1 && k < 24)
      begin
        @(negedge clk);
        k++;
      end
      pd = freq_mode ? ((mi >= fi) ? 32'h8000 : (mi * 32768) / fi) : pd;
      cmp(duty_ff.duty, pd, "duty");
    end
    for (int c = 0; c < 4; c++)
      for (int m = 0; m < 2; m++)
      begin
        n = 8 << c;
        w(8'hA8, 32'(c) << 14 | 32'(m) << 11);
        speed_below = 1'b1;
        repeat (n - 2) @(negedge clk);
        speed_below = 1'b0;
        @(negedge clk);
        speed_below = 1'b1;
        repeat (n - 3) @(negedge clk);
        cmp({standby_ff, sleep_ff}, 0, "early idle");
        k = 0;
        while ((standby_ff | sleep_ff) !== 1'b1 && k < 8)
        begin
          @(negedge clk);
          k++;
        end
        cmp({standby_ff, sleep_ff}, m ? 1 : 2, "idle");
        speed_below = 1'b0;
        repeat (2) @(negedge clk);
        cmp({standby_ff, sleep_ff}, 0, "wake");
      end
    for (int g = 0; g < 2; g++)
    begin
      w(8'hA8, g ? 32'h0000_1000 : 32'h0000_2000);
      cc = 0;
      cv = 0;
      repeat (200)
      begin
        @(negedge clk);
        cc += cur_gain_adj_ff;
        cv += volt_gain_adj_ff;
        // Reference run length: standby only after eight high samples in a row
        cmp({standby_ff, sleep_ff}, (rl >= 8) ? 2 : 0, "idle run");
        speed_below = ($random(seed) & 3) != 0;
        rl = speed_below ? rl + 1 : 0;
      end
      speed_below = 1'b0;
      rl = 0;
      cmp(cc, g ? 0 : 10, "cur gain");
      cmp(cv, g ? 10 : 0, "volt gain");
    end
    w(8'hA8, 32'h0000_0012);
    repeat (3)
    begin
      cwc_host_i.tickle(1'b1);
      repeat (1500) @(negedge clk);
    end
    cmp(wd_fault_ff, 0, "fed");
    repeat (400)
    begin
      @(negedge clk);
      fault_clear = 1'($random(seed));
    end
    // Clear held across the expiry: the set must still show for one cycle
    fault_clear = 1'b1;
    wait_fault(200);
    cmp({wd_fault_ff, outputs_hiz_ff}, 2, "report");
    @(negedge clk);
    fault_clear = 1'b0;
    cmp(wd_fault_ff, 0, "clear");
    w(8'hA8, 32'h0000_0011);
    cwc_host_i.tickle(1'b0);
    cmp(wd_fault_ff, 0, "cleared");
    repeat (1000) @(negedge clk);
    cwc_host_i.tickle(1'b1);
    repeat (18800) @(negedge clk);
    cmp(wd_fault_ff, 0, "i2c span");
    wait_fault(300);
    cmp({wd_fault_ff, outputs_hiz_ff}, 3, "latch");
    w(8'hA8, 32'h0000_0002);
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    repeat (2200) @(negedge clk);
    cmp({wd_fault_ff, outputs_hiz_ff}, 0, "off");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    shadow[8'hA8] = 32'h0000_0000;
    shadow[8'hAA] = 32'h4000_0000;
    rchk(8'hA8);
    rchk(8'hAA);
    complete_run();
  end
endmodule
